// ---- common/pdu_pkg.sv ----
// Constants and types shared by the programmable datapath unit
package pdu_pkg;
  localparam int W = 8;
  localparam int BW = 16;
  localparam int AW = 5;
  localparam int ROUTE_N = 6;
  localparam int CTRL_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int CFG_N = 8;
  localparam int CFG_AW = 3;
  localparam int CFG_W = 16;
  localparam int COND_N = 16;
  localparam int SEL_W = 4;
  // Bus addresses; ADDR_ACC0, ADDR_DAT0 and ADDR_Q0 each start a pair, ADDR_CFG starts eight words, the rest are one register each
  localparam logic [AW-1:0] ADDR_ACC0 = 5'h00;
  localparam logic [AW-1:0] ADDR_DAT0 = 5'h02;
  localparam logic [AW-1:0] ADDR_Q0 = 5'h04;
  localparam logic [AW-1:0] ADDR_CTRL = 5'h06;
  localparam logic [AW-1:0] ADDR_STATUS = 5'h07;
  localparam logic [AW-1:0] ADDR_CFG = 5'h08;
  localparam logic [AW-1:0] ADDR_STATIC = 5'h10;
  localparam logic [AW-1:0] ADDR_OSEL0 = 5'h11;
  localparam logic [AW-1:0] ADDR_OSEL1 = 5'h12;
  localparam logic [AW-1:0] ADDR_CMASK = 5'h13;
  localparam logic [AW-1:0] ADDR_POLY = 5'h14;
  localparam logic [AW-1:0] ADDR_STICKY = 5'h15;
  // Configuration word fields
  localparam int CW_FUNC = 0;
  localparam int CW_SRCA = 3;
  localparam int CW_SRCB = 5;
  localparam int CW_SHIFT = 7;
  localparam int CW_ORM = 9;
  localparam int CW_DEST = 10;
  localparam int CW_WE = 11;
  localparam int CW_CIN = 12;
  localparam int CW_SIN = 13;
  localparam int CW_Q0 = 14;
  // Static configuration fields
  localparam int ST_MSB = 0;
  localparam int ST_Q0OUT = 3;
  localparam int ST_Q0ACC = 5;
  localparam int ST_CMPP = 7;
  localparam int ST_CRC = 8;
  localparam int ST_CHAIN = 9;
  localparam int ST_DPEN = 10;
  localparam int ST_SCEN = 11;
  // Routing input fields
  localparam int RI_ADDR = 0;
  localparam int RI_SIN = 3;
  localparam int RI_CIN = 4;
  localparam int RI_STAT = 5;
  // Reset values
  localparam logic [BW-1:0] STATIC_RST = 16'h0c07;
  localparam logic [BW-1:0] CMASK_RST = 16'hffff;
  localparam logic [BW-1:0] ZERO_RST = 16'h0000;
  typedef enum logic [2:0] {
    FN_INC, FN_DEC, FN_ADD, FN_SUB, FN_AND, FN_OR, FN_XOR, FN_PASS
  } pdu_func_e;
  typedef enum logic [1:0] {SH_NONE, SH_LEFT, SH_RIGHT, SH_SWAP} pdu_shift_e;
endpackage : pdu_pkg

// ---- src/pdu_fifo.sv ----
// Parameterised FIFO with valid and ready on both sides
module pdu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  logic push;
  logic pop;

  // Refused transfers never move pointers; depth must be a power of two
  assign in_ready = cnt_q != (PW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];

  // Storage, no reset needed
  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  refused_push_a: assert property (in_valid && !in_ready && !pop |=> $stable(cnt_q))
    else $error("push into full fifo changed its level");
  refused_pop_a: assert property (out_ready && !out_valid && !push |=> cnt_q == '0)
    else $error("pop from empty fifo changed its level");
endmodule : pdu_fifo

// ---- src/pdu_cfg_ram.sv ----
// Eight-word configuration store with a combinational read port
module pdu_cfg_ram (
  input wire logic clock,
  input wire logic resetn,
  input wire logic we,
  input wire logic [pdu_pkg::CFG_AW-1:0] waddr,
  input wire logic [pdu_pkg::CFG_W-1:0] wdata,
  input wire logic [pdu_pkg::CFG_AW-1:0] raddr,
  output logic [pdu_pkg::CFG_W-1:0] rdata
);
  import pdu_pkg::*;
  logic [CFG_W-1:0] mem_q [CFG_N];

  // Read is not registered so the addressed word acts in its own cycle
  assign rdata = mem_q[raddr];

  // Words held in flops, cleared at reset
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < CFG_N; i++) mem_q[i] <= ZERO_RST;
    end
    else if (we)
    begin
      mem_q[waddr] <= wdata;
    end
  end
endmodule : pdu_cfg_ram

// ---- src/pdu_top.sv ----
// Programmable datapath slice with its status and control register
//
// How it works
// - Eight-bit ALU finishes each operation in one clock.
// - Six working registers: two accumulators, two data registers, two FIFOs.
// - Accumulators serve as ALU operands, ALU destinations and compare operands.
// - Data registers are ALU and compare operands, never ALU destinations.
// - Each FIFO holds four bytes, loads registers or captures accumulator/ALU.
// - Eight sixteen-bit configuration words; addressed word sets each cycle's function.
// - ALU offers increment, decrement, add, subtract, AND, OR, XOR, pass.
// - Optional shift left, shift right, nibble swap or OR mask on result.
// - Two masked comparators with configurable operand pairings.
// - Zero, all-ones and overflow conditions; selectable onto routing outputs.
// - Optional carry, shift and condition chaining with neighbouring slices.
// - Programmable most significant bit for arithmetic and shifts.
// - One CRC or PRS step per cycle, programmable polynomial and width.
// - Each FIFO is independently an input or output buffer.
// - FIFO status is selectable onto routing outputs.
// - Carry-out and shift-out are registered and reusable later.
// - Six routing inputs, six routing outputs selected from conditions.
// - Bus-written control register drives routing bits.
// - Read-only status register shows internal routing signals.
// - Status bit may latch a pulse and clears on bus read.
// - Datapath and status latch each have their own enable.
module pdu_top (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [pdu_pkg::AW-1:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [pdu_pkg::BW-1:0] bus_wdata,
  output logic [pdu_pkg::BW-1:0] bus_rdata,
  input wire logic [pdu_pkg::ROUTE_N-1:0] route_in,
  output logic [pdu_pkg::ROUTE_N-1:0] route_out,
  output logic [pdu_pkg::CTRL_W-1:0] ctrl_out,
  input wire logic chain_cin,
  input wire logic chain_sin,
  input wire logic chain_cond_in,
  output logic chain_cout,
  output logic chain_sout,
  output logic chain_cond_out
);
  import pdu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State and configuration
  logic [W-1:0] acc_q [2];
  logic [W-1:0] dat_q [2];
  logic [BW-1:0] static_q;
  logic [BW-1:0] osel0_q;
  logic [BW-1:0] osel1_q;
  logic [BW-1:0] cmask_q;
  logic [BW-1:0] poly_q;
  logic [W-1:0] sticky_en_q;
  logic [W-1:0] sticky_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic carry_q;
  logic sout_q;
  logic [CFG_W-1:0] cw;
  logic [W-1:0] src [4];
  logic [W-1:0] opa;
  logic [W-1:0] opb;
  logic [2:0] msb;
  logic [W:0] mask_ext;
  logic [W-1:0] wmask;
  pdu_func_e func;
  pdu_shift_e shift;
  logic crc_on;
  logic chain_on;
  logic dp_en;
  logic sc_en;
  logic cin_route;
  logic sin_route;
  logic cin_use;
  logic si;
  logic [W:0] sum;
  logic [W-1:0] bx;
  logic [W-1:0] alu_r;
  logic [W-1:0] res;
  logic cout;
  logic sout;
  logic ov;
  logic fb;
  logic dp_go;
  logic [1:0] blocked;
  logic [1:0] q_dir;
  logic [1:0] q_tgt;
  logic [1:0] q_op;
  logic [1:0] q_in_ready;
  logic [1:0] q_out_valid;
  logic [W-1:0] q_rdata [2];
  logic [1:0] load_acc;
  logic [1:0] load_dat;
  logic [W-1:0] cmp_b [2];
  logic [1:0] ceq;
  logic [1:0] clt;
  logic [COND_N-1:0] cond;
  logic [W-1:0] stat_raw;
  logic rd_status;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration word and static fields
  pdu_cfg_ram u_cfg (
    .clock(clock),
    .resetn(resetn),
    .we(bus_wr && bus_addr[AW-1:CFG_AW] == ADDR_CFG[AW-1:CFG_AW]),
    .waddr(bus_addr[CFG_AW-1:0]),
    .wdata(bus_wdata),
    .raddr(route_in[RI_ADDR +: CFG_AW]),
    .rdata(cw)
  );

  assign func = pdu_func_e'(cw[CW_FUNC +: 3]);
  assign shift = pdu_shift_e'(cw[CW_SHIFT +: 2]);
  assign msb = static_q[ST_MSB +: 3];
  assign crc_on = static_q[ST_CRC];
  assign chain_on = static_q[ST_CHAIN];
  assign dp_en = static_q[ST_DPEN];
  assign sc_en = static_q[ST_SCEN];

  // Operand selection from accumulators and data registers
  assign src[0] = acc_q[0];
  assign src[1] = acc_q[1];
  assign src[2] = dat_q[0];
  assign src[3] = dat_q[1];
  assign opa = src[cw[CW_SRCA +: 2]];
  assign opb = src[cw[CW_SRCB +: 2]];

  // Width mask from the programmable top bit
  assign mask_ext = (9'h002 << msb) - 9'h001;
  assign wmask = mask_ext[W-1:0];

  // Carry and serial input: own registered copy, neighbour, or routing
  assign cin_route = chain_on ? chain_cin : route_in[RI_CIN];
  assign sin_route = chain_on ? chain_sin : route_in[RI_SIN];
  assign cin_use = cw[CW_CIN] ? carry_q : cin_route;
  assign si = cw[CW_SIN] ? sout_q : sin_route;

  ////////////////////////////////////////////////////////////////////////////
  // ALU, single cycle
  always_comb
  begin
    bx = wmask;
    sum = '0;
    unique case (func)
      FN_INC: sum = {1'b0, opa & wmask} + 9'h001;
      FN_DEC: sum = {1'b0, opa & wmask} + {1'b0, wmask};
      FN_ADD:
      begin
        bx = opb & wmask;
        sum = {1'b0, opa & wmask} + {1'b0, bx} + {8'h00, cin_use};
      end
      FN_SUB:
      begin
        bx = ~opb & wmask;
        sum = {1'b0, opa & wmask} + {1'b0, bx} + {8'h00, cw[CW_CIN] ? carry_q : 1'b1};
      end
      FN_AND: sum = {1'b0, opa & opb};
      FN_OR: sum = {1'b0, opa | opb};
      FN_XOR: sum = {1'b0, opa ^ opb};
      FN_PASS: sum = {1'b0, opa};
    endcase
  end

  // Carry and overflow at the programmable top bit; CRC step replaces it
  always_comb
  begin
    fb = opa[msb] ^ si;
    cout = sum[{1'b0, msb} + 4'h1];
    ov = (func <= FN_SUB) && (opa[msb] == bx[msb]) && (sum[msb] != opa[msb]);
    alu_r = sum[W-1:0] & wmask;
    if (crc_on)
    begin
      alu_r = ({opa[W-2:0], 1'b0} ^ (fb ? poly_q[W-1:0] : 8'h00)) & wmask;
      cout = fb;
      ov = 1'b0;
    end
  end

  // Post-ALU shift, swap and OR mask
  always_comb
  begin
    res = alu_r;
    sout = crc_on ? fb : 1'b0;
    unique case (shift)
      SH_NONE: res = alu_r;
      SH_LEFT:
      begin
        sout = alu_r[msb];
        res = {alu_r[W-2:0], si} & wmask;
      end
      SH_RIGHT:
      begin
        sout = alu_r[0];
        res = alu_r >> 1;
        res[msb] = si;
      end
      SH_SWAP: res = {alu_r[3:0], alu_r[7:4]} & wmask; // Keeps bits above the top bit clear
    endcase
    if (cw[CW_ORM]) res = res | poly_q[BW-1:W];
  end

  ////////////////////////////////////////////////////////////////////////////
  // FIFOs, working registers; a stalled FIFO op stalls the whole cycle
  assign dp_go = dp_en && (blocked == 2'b00);

  for (genvar k = 0; k < 2; k++)
  begin : g_slice
    logic bus_q_wr;
    logic bus_q_rd;
    assign q_dir[k] = static_q[ST_Q0OUT + k];
    assign q_tgt[k] = static_q[ST_Q0ACC + k];
    assign q_op[k] = cw[CW_Q0 + k];
    assign bus_q_wr = bus_wr && bus_addr == ADDR_Q0 + AW'(k);
    assign bus_q_rd = bus_rd && bus_addr == ADDR_Q0 + AW'(k);
    assign blocked[k] = q_op[k] && (q_dir[k] ? !q_in_ready[k] : !q_out_valid[k]);
    assign load_acc[k] = dp_go && q_op[k] && !q_dir[k] && q_tgt[k];
    assign load_dat[k] = dp_go && q_op[k] && !q_dir[k] && !q_tgt[k];

    pdu_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock(clock),
      .resetn(resetn),
      .in_valid(q_dir[k] ? dp_go && q_op[k] : bus_q_wr),
      .in_ready(q_in_ready[k]),
      .in_data(!q_dir[k] ? bus_wdata[W-1:0] : (q_tgt[k] ? acc_q[k] : res)),
      .out_valid(q_out_valid[k]),
      .out_ready(q_dir[k] ? bus_q_rd : dp_go && q_op[k]),
      .out_data(q_rdata[k])
    );

    // Accumulator: FIFO load, then ALU result, then bus write
    always_ff @(posedge clock or negedge resetn)
    begin
      if (!resetn)
        acc_q[k] <= 8'h00;
      else if (load_acc[k])
        acc_q[k] <= q_rdata[k];
      else if (dp_go && cw[CW_WE] && cw[CW_DEST] == 1'(k))
        acc_q[k] <= res;
      else if (bus_wr && bus_addr == ADDR_ACC0 + AW'(k))
        acc_q[k] <= bus_wdata[W-1:0];
    end

    // Data register: never an ALU destination
    always_ff @(posedge clock or negedge resetn)
    begin
      if (!resetn)
        dat_q[k] <= 8'h00;
      else if (load_dat[k])
        dat_q[k] <= q_rdata[k];
      else if (bus_wr && bus_addr == ADDR_DAT0 + AW'(k))
        dat_q[k] <= bus_wdata[W-1:0];
    end

    // Masked compare, pairing chosen statically
    assign cmp_b[k] = static_q[ST_CMPP] ? acc_q[1-k] : dat_q[k];
    assign ceq[k] = (acc_q[k] & cmask_q[W*k +: W]) == (cmp_b[k] & cmask_q[W*k +: W]);
    assign clt[k] = (acc_q[k] & cmask_q[W*k +: W]) < (cmp_b[k] & cmask_q[W*k +: W]);
  end

  // Registered carry and shift out for later cycles
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      carry_q <= 1'b0;
      sout_q <= 1'b0;
    end
    else if (dp_go)
    begin
      carry_q <= cout;
      sout_q <= sout;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conditions and routing outputs
  assign cond = {chain_cond_in, !q_in_ready[1], !q_out_valid[1], !q_in_ready[0],
    !q_out_valid[0], sout, carry_q, ov, acc_q[1] == 8'hff, acc_q[0] == 8'hff,
    acc_q[1] == 8'h00, acc_q[0] == 8'h00, clt[1], ceq[1], clt[0], ceq[0]};
  assign chain_cout = cout;
  assign chain_sout = sout;
  assign chain_cond_out = ceq[0];

  for (genvar j = 0; j < ROUTE_N; j++)
  begin : g_route
    logic [SEL_W-1:0] sel;
    assign sel = (j < 3) ? osel0_q[SEL_W*(j%3) +: SEL_W] : osel1_q[SEL_W*(j%3) +: SEL_W];
    // Registered so the routing sees a clean level
    always_ff @(posedge clock or negedge resetn)
    begin
      if (!resetn)
        route_out[j] <= 1'b0;
      else if (dp_en)
        route_out[j] <= cond[sel];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status and control
  assign stat_raw = {!q_in_ready[1], !q_out_valid[1], !q_in_ready[0], !q_out_valid[0],
    ov, route_in[RI_STAT], ceq[1], ceq[0]};
  assign rd_status = bus_rd && bus_addr == ADDR_STATUS;
  assign ctrl_out = ctrl_q;

  // Latched pulses; a new set in the read cycle survives the clear
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      sticky_q <= 8'h00;
    else
      sticky_q <= (rd_status ? 8'h00 : sticky_q) | (sc_en ? stat_raw & sticky_en_q : 8'h00);
  end

  // Bus-written configuration
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      static_q <= STATIC_RST;
      osel0_q <= ZERO_RST;
      osel1_q <= ZERO_RST;
      cmask_q <= CMASK_RST;
      poly_q <= ZERO_RST;
      sticky_en_q <= 8'h00;
      ctrl_q <= 8'h00;
    end
    else if (bus_wr)
    begin
      unique case (bus_addr)
        ADDR_STATIC: static_q <= bus_wdata;
        ADDR_OSEL0: osel0_q <= bus_wdata;
        ADDR_OSEL1: osel1_q <= bus_wdata;
        ADDR_CMASK: cmask_q <= bus_wdata;
        ADDR_POLY: poly_q <= bus_wdata;
        ADDR_STICKY: sticky_en_q <= bus_wdata[W-1:0];
        ADDR_CTRL: ctrl_q <= bus_wdata[CTRL_W-1:0];
        default: ;
      endcase
    end
  end

  // Read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      bus_rdata <= ZERO_RST;
    else if (bus_rd)
    begin
      unique case (bus_addr)
        ADDR_ACC0, ADDR_ACC0 + 5'h01: bus_rdata <= {8'h00, acc_q[bus_addr[0]]};
        ADDR_DAT0, ADDR_DAT0 + 5'h01: bus_rdata <= {8'h00, dat_q[bus_addr[0]]};
        ADDR_Q0, ADDR_Q0 + 5'h01:
          bus_rdata <= {8'h00, q_out_valid[bus_addr[0]] ? q_rdata[bus_addr[0]] : 8'h00};
        ADDR_CTRL: bus_rdata <= {8'h00, ctrl_q};
        ADDR_STATUS:
          bus_rdata <= {8'h00, (sticky_q & sticky_en_q) | (stat_raw & ~sticky_en_q)};
        ADDR_STATIC: bus_rdata <= static_q;
        ADDR_OSEL0: bus_rdata <= osel0_q;
        ADDR_OSEL1: bus_rdata <= osel1_q;
        ADDR_CMASK: bus_rdata <= cmask_q;
        ADDR_POLY: bus_rdata <= poly_q;
        ADDR_STICKY: bus_rdata <= {8'h00, sticky_en_q};
        default: bus_rdata <= ZERO_RST;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  acc_dest_a: assert property (dp_go && cw[CW_WE] && !load_acc[cw[CW_DEST]]
    |=> acc_q[$past(cw[CW_DEST])] == $past(res))
    else $error("accumulator missed its ALU result");
  inc_step_a: assert property (dp_go && func == FN_INC && shift == SH_NONE && !cw[CW_ORM]
    && !crc_on && msb == 3'h7 && cw[CW_WE] && !load_acc[cw[CW_DEST]]
    |=> acc_q[$past(cw[CW_DEST])] == $past(opa) + 8'h01)
    else $error("increment result wrong");
  msb_mask_a: assert property (dp_go && cw[CW_WE] && !cw[CW_ORM] && !load_acc[cw[CW_DEST]]
    |=> (acc_q[$past(cw[CW_DEST])] & ~$past(wmask)) == 8'h00)
    else $error("bits above top bit written");
  data_hold_a: assert property (!load_dat[0] && !(bus_wr && bus_addr == ADDR_DAT0)
    |=> $stable(dat_q[0]))
    else $error("data register changed without a load");
  carry_keep_a: assert property (dp_go |=> carry_q == $past(cout))
    else $error("carry not registered");
  dp_hold_a: assert property (!dp_en |=> $stable(carry_q) && $stable(sout_q))
    else $error("datapath moved while disabled");
  sticky_clr_a: assert property (rd_status |=> (sticky_q & ~$past(stat_raw)) == 8'h00)
    else $error("status latch not cleared by read");
  ctrl_drive_a: assert property (bus_wr && bus_addr == ADDR_CTRL
    |=> ctrl_out == $past(bus_wdata[CTRL_W-1:0]))
    else $error("control bits not driven");
  route_sel_a: assert property (dp_en |=> route_out[0] == $past(cond[osel0_q[SEL_W-1:0]]))
    else $error("routing output selection wrong");
  cmp_excl_a: assert property (ceq[0] |-> !clt[0])
    else $error("compare equal and less at once");
endmodule : pdu_top

// ---- verif/pdu_seq_model.sv ----
// Sequencer model that steers the slice through its routing inputs
module pdu_seq_model (
  input wire logic clock,
  input wire logic resetn,
  input wire logic step,
  input wire logic [2:0] step_addr,
  input wire logic [2:0] side_bits,
  output logic [5:0] route
);
  timeunit 1ns;
  timeprecision 100ps;
  // Parks on word 1, left all zero, so idle cycles write no accumulator, data register or FIFO
  always @(posedge clock or negedge resetn)
    if (!resetn)
      route <= 6'h01;
    else
      route <= #1 {side_bits, step ? step_addr : 3'h1};
endmodule : pdu_seq_model

// ---- verif/pdu_bench.sv ----
// Self-checking bench for the datapath slice
module pdu_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import pdu_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [AW-1:0] bus_addr = 5'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [BW-1:0] bus_wdata = 16'h0000;
  logic [BW-1:0] bus_rdata;
  logic [ROUTE_N-1:0] route_in;
  logic [ROUTE_N-1:0] route_out;
  logic [CTRL_W-1:0] ctrl_out;
  logic [2:0] chain_in = 3'h0;
  logic [2:0] chain_out;
  logic step = 1'b0;
  logic [2:0] step_addr = 3'h0;
  logic [2:0] side_bits = 3'h0;
  logic [31:0] seed = 32'h3e73_c32e;
  int err_total = 0;
  int n_tests = 0;
  int cycles = 0;
  int q[$];
  int a, b, m, e, v;
  ////////////////////////////////////////////////////////////////////
  // Clock, device and sequencer
  always #2 clock = ~clock;
  pdu_top pdu_top_i (.clock(clock), .resetn(resetn), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .route_in(route_in), .route_out(route_out), .ctrl_out(ctrl_out),
    .chain_cin(chain_in[0]), .chain_sin(chain_in[1]), .chain_cond_in(chain_in[2]),
    .chain_cout(chain_out[0]), .chain_sout(chain_out[1]), .chain_cond_out(chain_out[2]));
  pdu_seq_model pdu_seq_model_i (.clock(clock), .resetn(resetn), .step(step),
    .step_addr(step_addr), .side_bits(side_bits), .route(route_in));
  ////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic int rnd8();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed[7:0]);
  endfunction : rnd8
  // Reference result; shift in and carry in are held at zero
  function automatic int model(int k, int x, int y, int mk);
    case (k)
      0: return (x + 1) & 255;
      1: return (x - 1) & 255;
      2: return (x + y) & 255;
      3: return (x - y) & 255;
      4: return x & y;
      5: return x | y;
      6: return x ^ y;
      7: return x;
      8: return (x << 1) & 255;
      9: return x >> 1;
      10: return ((x << 4) | (x >> 4)) & 255;
      default: return x | mk;
    endcase
  endfunction : model
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(logic [4:0] ad, int d);
    @(posedge clock);
    #1;
    bus_addr = ad;
    bus_wdata = 16'(d);
    bus_wr = 1'b1;
    @(posedge clock);
    #1;
    bus_wr = 1'b0;
  endtask : wr
  // Read data is registered, so it is settled one edge after the strobe
  task automatic rdchk(string name, logic [4:0] ad, logic [15:0] mk, int exp);
    @(posedge clock);
    #1;
    bus_addr = ad;
    bus_rd = 1'b1;
    @(posedge clock);
    #1;
    bus_rd = 1'b0;
    check(name, bus_rdata & mk, 16'(exp));
  endtask : rdchk
  // One cycle on word ad; the state lands on the edge that closes it
  task automatic run(logic [2:0] ad);
    @(posedge clock);
    #1;
    step = 1'b1;
    step_addr = ad;
    @(posedge clock);
    #1;
    step = 1'b0;
  endtask : run
  task automatic conclude();
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // Hang guard, far above the 200 or so cycles the run needs
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clock);
    #1;
    resetn = 1'b1;
    chain_in = 3'(rnd8());
    check("ctrl_rst", 16'(ctrl_out), 16'h0000);
    rdchk("static", ADDR_STATIC, 16'hffff, STATIC_RST);
    rdchk("unmapped", 5'h1f, 16'hffff, 0);
    rdchk("status_rst", ADDR_STATUS, 16'h00f4, 16'h0050);
    v = rnd8();
    wr(ADDR_CTRL, v);
    check("ctrl", 16'(ctrl_out), 16'(v));
    // Every operation, then each shift and the OR mask on a pass
    for (int k = 0; k < 12; k++)
    begin
      a = rnd8();
      b = rnd8();
      m = rnd8();
      wr(ADDR_ACC0, a);
      wr(ADDR_DAT0, b);
      wr(ADDR_POLY, m << 8);
      if (k < 8)
        v = k;
      else if (k < 11)
        v = 7 | ((k - 7) << CW_SHIFT);
      else
        v = 7 | (1 << CW_ORM);
      wr(ADDR_CFG, v | (2 << CW_SRCB) | (1 << CW_WE));
      run(3'h0);
      rdchk("alu", ADDR_ACC0, 16'h00ff, model(k, a, b, m));
    end
    // Overfill the input queue; the fifth write must be dropped
    side_bits = 3'h4;
    for (int i = 0; i < 5; i++)
    begin
      v = rnd8();
      wr(ADDR_Q0, v);
      if (q.size() < FIFO_DEPTH)
        q.push_back(v);
    end
    rdchk("status_full", ADDR_STATUS, 16'h00f4, 16'h0064);
    rdchk("head", ADDR_Q0, 16'h00ff, q[0]);
    wr(ADDR_CFG + 5'h02, 1 << CW_Q0);
    // Drain into the data register; the pop from empty changes nothing
    for (int i = 0; i < 5; i++)
    begin
      run(3'h2);
      if (q.size() > 0)
        e = q.pop_front();
      rdchk("pop", ADDR_DAT0, 16'h00ff, e);
    end
    rdchk("status_empty", ADDR_STATUS, 16'h00f4, 16'h0054);
    // Queue 0 empty onto output 0, queue 0 full onto output 1
    wr(ADDR_OSEL0, 16'h00cb);
    rdchk("osel0", ADDR_OSEL0, 16'hffff, 16'h00cb);
    check("route_fifo", 16'(route_out[1:0]), 16'h0001);
    conclude();
  end
endmodule : pdu_bench
